// file: shared/setfeat_pkg.sv
// Constants, register map and types of the feature-setting command decoder
package setfeat_pkg;
	localparam logic [7:0] OPC_SET_FEATURES = 8'hEF;
	localparam logic [7:0] DEV_REQ_MASK = 8'hA0;
	localparam logic [7:0] FC_WC_ON = 8'h02;
	localparam logic [7:0] FC_XFER = 8'h03;
	localparam logic [7:0] FC_PM_ON = 8'h05;
	localparam logic [7:0] FC_PUIS_ON = 8'h06;
	localparam logic [7:0] FC_SPINUP = 8'h07;
	localparam logic [7:0] FC_SER_ON = 8'h10;
	localparam logic [7:0] FC_SECT_TIME = 8'h43;
	localparam logic [7:0] FC_EPC = 8'h4A;
	localparam logic [7:0] FC_RLA_OFF = 8'h55;
	localparam logic [7:0] FC_REV_OFF = 8'h66;
	localparam logic [7:0] FC_WC_OFF = 8'h82;
	localparam logic [7:0] FC_PM_OFF = 8'h85;
	localparam logic [7:0] FC_PUIS_OFF = 8'h86;
	localparam logic [7:0] FC_SER_OFF = 8'h90;
	localparam logic [7:0] FC_RLA_ON = 8'hAA;
	localparam logic [7:0] FC_REV_ON = 8'hCC;
	localparam logic [4:0] XT_PIO_DEF = 5'h00;
	localparam logic [4:0] XT_PIO_FLOW = 5'h01;
	localparam logic [4:0] XT_MDMA = 5'h04;
	localparam logic [4:0] XT_UDMA = 5'h08;
	localparam logic [2:0] XM_PIO_MAX = 3'h4;
	localparam logic [2:0] XM_MDMA_MAX = 3'h2;
	localparam logic [2:0] XM_UDMA_MAX = 3'h6;
	localparam logic [7:0] LVL_LP_BASE = 8'h80;
	localparam logic [7:0] LVL_NORMAL_BASE = 8'hC0;
	localparam logic [7:0] LVL_RS_BASE = 8'h40;
	localparam logic [7:0] LVL_ABORT_HI = 8'hFF;
	localparam logic [7:0] LVL_ABORT_LO = 8'h00;
	localparam logic [15:0] LP_STEP_S = 16'h0005;
	localparam logic [15:0] LP_BASE_S = 16'h0078;
	localparam logic [15:0] RS_STEP_S = 16'h003C;
	localparam logic [15:0] RS_BASE_S = 16'h0258;
	localparam int ERR_ABORTED_BIT = 2;
	localparam int ST_ERR_BIT = 0;
	localparam int ST_COR_BIT = 2;
	localparam int ST_DF_BIT = 5;
	localparam int ST_RDY_BIT = 6;
	localparam int ST_BSY_BIT = 7;
	localparam logic [11:0] A_FEATURE = 12'h000;
	localparam logic [11:0] A_COUNT = 12'h004;
	localparam logic [11:0] A_LBA_LO = 12'h008;
	localparam logic [11:0] A_LBA_MID = 12'h00C;
	localparam logic [11:0] A_LBA_HI = 12'h010;
	localparam logic [11:0] A_DEVICE = 12'h014;
	localparam logic [11:0] A_COMMAND = 12'h018;
	localparam logic [11:0] A_FAULT = 12'h01C;
	localparam logic [11:0] A_STATE = 12'h020;
	localparam logic [11:0] A_FEATSTAT = 12'h024;
	localparam logic [11:0] A_XFER = 12'h028;
	localparam logic [11:0] A_DELAYS = 12'h02C;
	localparam logic [11:0] A_SECTIME = 12'h030;
	localparam logic [11:0] A_CTRL = 12'h034;
	localparam logic [31:0] STATE_RESET = 32'h0000_0040;

	typedef enum logic [1:0] {
		DEEP_NORMAL = 2'b00,
		DEEP_LOW_POWER = 2'b01,
		DEEP_REDUCED = 2'b10
	} deep_state_t;

	typedef struct packed {
		deep_state_t deep;
		logic lp_set;
		logic [15:0] lp_delay;
		logic [15:0] rs_delay;
	} pm_cfg_t;

	typedef struct packed {
		logic [7:0] feature;
		logic [7:0] count;
		logic [7:0] lba_lo;
		logic [7:0] lba_mid;
		logic [7:0] lba_hi;
		logic [7:0] device;
	} cmd_block_t;
endpackage

// file: verilog/set_features_command_decoder.sv
// APB-reached decoder and feature state of the feature-setting command
`timescale 1ns/1ps
`default_nettype none
module set_features_command_decoder (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic write_cache_on,
	output logic spin_up_pulse
);
	import setfeat_pkg::*;

	cmd_block_t cb_r, cb_nxt;
	logic [7:0] fault_r, fault_nxt;
	logic [7:0] state_r, state_nxt;
	logic wc_r, wc_nxt, rla_r, rla_nxt, rev_r, rev_nxt, irq_rel_r;
	logic pm_en_r, pm_en_nxt, puis_r, puis_nxt, spin_r, spin_nxt;
	logic [5:0] ser_r, ser_nxt;
	logic [7:0] xfer_r, xfer_nxt;
	logic [15:0] pio_t_r, pio_t_nxt, dma_t_r, dma_t_nxt;
	logic exhaust_r, exhaust_nxt;
	pm_cfg_t pm_r, pm_nxt;
	logic [31:0] rd_nxt, prdata_nxt;
	logic pready_nxt, pslverr_nxt, irq_rel_nxt;
	logic err_nxt, done_nxt;

	wire logic wr = psel & penable & pwrite;
	wire logic cmd_go = wr && paddr == A_COMMAND && pwdata[7:0] == OPC_SET_FEATURES;

	// Checks a transfer-mode byte against the legal type and mode pairs
	function automatic logic xfer_ok(input logic [7:0] v);
		logic [4:0] t;
		logic [2:0] m;
		t = v[7:3];
		m = v[2:0];
		unique case (t)
			XT_PIO_DEF: xfer_ok = m <= 3'h1;
			XT_PIO_FLOW: xfer_ok = m <= XM_PIO_MAX;
			XT_MDMA: xfer_ok = m <= XM_MDMA_MAX;
			XT_UDMA: xfer_ok = m <= XM_UDMA_MAX;
			default: xfer_ok = 1'b0;
		endcase
	endfunction

	// Maps a serial option selector onto its bit, zero when undefined
	function automatic logic [5:0] ser_bit(input logic [7:0] v);
		unique case (v)
			8'h01, 8'h02, 8'h03, 8'h04, 8'h06: ser_bit = 6'h01 << (v[2:0] - 3'h1);
			default: ser_bit = 6'h00;
		endcase
	endfunction

	// Parameter stores; the decode reads them only when the opcode lands
	always_comb begin
		cb_nxt = cb_r;
		if (wr) begin
			unique case (paddr)
				A_FEATURE: cb_nxt.feature = pwdata[7:0];
				A_COUNT: cb_nxt.count = pwdata[7:0];
				A_LBA_LO: cb_nxt.lba_lo = pwdata[7:0];
				A_LBA_MID: cb_nxt.lba_mid = pwdata[7:0];
				A_LBA_HI: cb_nxt.lba_hi = pwdata[7:0];
				A_DEVICE: cb_nxt.device = pwdata[7:0];
				default: ;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cb_r <= '0;
		end else begin
			cb_r <= cb_nxt;
		end
	end

	always_comb begin
		irq_rel_nxt = irq_rel_r;
		done_nxt = 1'b0;
		wc_nxt = wc_r;
		rla_nxt = rla_r;
		rev_nxt = rev_r;
		pm_en_nxt = pm_en_r;
		puis_nxt = puis_r;
		spin_nxt = 1'b0;
		ser_nxt = ser_r;
		xfer_nxt = xfer_r;
		pio_t_nxt = pio_t_r;
		dma_t_nxt = dma_t_r;
		exhaust_nxt = exhaust_r;
		pm_nxt = pm_r;
		err_nxt = 1'b0;
		// Control word: sticky exhaustion and, while reverting is on, a clear of power management
		if (wr && paddr == A_CTRL) begin
			exhaust_nxt = exhaust_r | pwdata[0];
			if (pwdata[1] && rev_r) begin
				pm_en_nxt = 1'b0;
				pm_nxt = '0;
			end
		end
		if (cmd_go && (cb_r.device & DEV_REQ_MASK) == DEV_REQ_MASK) begin
			unique case (cb_r.feature)
				FC_WC_ON: wc_nxt = 1'b1;
				FC_WC_OFF: wc_nxt = 1'b0;
				FC_RLA_ON: rla_nxt = 1'b1;
				FC_RLA_OFF: rla_nxt = 1'b0;
				FC_REV_ON: rev_nxt = 1'b1;
				FC_REV_OFF: rev_nxt = 1'b0;
				FC_XFER: begin
					// An illegal pair aborts and leaves the active mode in force
					if (xfer_ok(cb_r.count)) begin
						xfer_nxt = cb_r.count;
					end else begin
						err_nxt = 1'b1;
					end
				end
				FC_PUIS_ON: puis_nxt = 1'b1;
				FC_PUIS_OFF: puis_nxt = 1'b0;
				// Accepted either way; only an armed standby feature pulses
				FC_SPINUP: spin_nxt = puis_r;
				FC_SER_ON, FC_SER_OFF: begin
					if (ser_bit(cb_r.count) == 6'h00) begin
						err_nxt = 1'b1;
					end else if (cb_r.feature == FC_SER_ON) begin
						ser_nxt = ser_r | ser_bit(cb_r.count);
					end else begin
						ser_nxt = ser_r & ~ser_bit(cb_r.count);
					end
				end
				FC_SECT_TIME: begin
					pio_t_nxt = {cb_r.lba_lo, cb_r.count};
					dma_t_nxt = {cb_r.lba_hi, cb_r.lba_mid};
				end
				FC_EPC: ;
				FC_PM_OFF: begin
					pm_en_nxt = 1'b0;
					pm_nxt = '0;
				end
				FC_PM_ON: begin
					if (cb_r.count == LVL_ABORT_HI || cb_r.count == LVL_ABORT_LO) begin
						err_nxt = 1'b1;
					end else if (cb_r.count >= LVL_NORMAL_BASE) begin
						pm_en_nxt = 1'b1;
						pm_nxt = '0;
					end else if (cb_r.count >= LVL_LP_BASE) begin
						pm_en_nxt = 1'b1;
						pm_nxt.deep = DEEP_LOW_POWER;
						pm_nxt.lp_set = 1'b1;
						pm_nxt.lp_delay = 16'(16'(cb_r.count - LVL_LP_BASE) * LP_STEP_S)
							+ LP_BASE_S;
						pm_nxt.rs_delay = 16'h0000;
					end else begin
						pm_en_nxt = 1'b1;
						pm_nxt.deep = DEEP_REDUCED;
						if (!pm_r.lp_set) begin
							pm_nxt.lp_set = 1'b1;
							pm_nxt.lp_delay = LP_BASE_S;
						end
						if (cb_r.count >= LVL_RS_BASE) begin
							pm_nxt.rs_delay = 16'(16'(cb_r.count - LVL_RS_BASE) * RS_STEP_S)
								+ RS_BASE_S;
						end else begin
							pm_nxt.rs_delay = RS_BASE_S;
						end
					end
				end
				default: err_nxt = 1'b1;
			endcase
			if (exhaust_nxt) begin
				wc_nxt = 1'b0;
			end
			done_nxt = 1'b1;
		end
		if (exhaust_nxt) begin
			wc_nxt = 1'b0;
		end
	end

	always_comb begin
		fault_nxt = fault_r;
		state_nxt = state_r;
		if (done_nxt) begin
			fault_nxt = 8'h00;
			fault_nxt[ERR_ABORTED_BIT] = err_nxt;
			state_nxt[ST_BSY_BIT] = 1'b0;
			state_nxt[ST_DF_BIT] = 1'b0;
			state_nxt[ST_COR_BIT] = 1'b0;
			state_nxt[ST_RDY_BIT] = 1'b1;
			state_nxt[ST_ERR_BIT] = err_nxt;
		end
	end

	always_comb begin
		unique case (paddr)
			A_FEATURE: rd_nxt = {24'h00_0000, cb_r.feature};
			A_COUNT: rd_nxt = {24'h00_0000, cb_r.count};
			A_LBA_LO: rd_nxt = {24'h00_0000, cb_r.lba_lo};
			A_LBA_MID: rd_nxt = {24'h00_0000, cb_r.lba_mid};
			A_LBA_HI: rd_nxt = {24'h00_0000, cb_r.lba_hi};
			A_DEVICE: rd_nxt = {24'h00_0000, cb_r.device};
			A_FAULT: rd_nxt = {24'h00_0000, fault_r};
			A_STATE: rd_nxt = {24'h00_0000, state_r};
			A_FEATSTAT: rd_nxt = {15'h0000, 2'b00, ser_r, exhaust_r, irq_rel_r, puis_r,
				pm_en_r, pm_r.deep, rev_r, rla_r, wc_r};
			A_XFER: rd_nxt = {24'h00_0000, xfer_r};
			A_DELAYS: rd_nxt = {pm_r.rs_delay, pm_r.lp_delay};
			A_SECTIME: rd_nxt = {dma_t_r, pio_t_r};
			default: rd_nxt = 32'h0000_0000;
		endcase
	end

	// Zero-wait slave: access phase completes in its first cycle
	always_comb begin
		prdata_nxt = prdata;
		pready_nxt = psel & ~penable;
		pslverr_nxt = 1'b0;
		// Read data is caught in setup so that it stands through the access phase
		if (psel && !penable && !pwrite) begin
			prdata_nxt = rd_nxt;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			prdata <= prdata_nxt;
			pready <= pready_nxt;
			pslverr <= pslverr_nxt;
		end
	end

	// Returned status of the last accepted command
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fault_r <= 8'h00;
			state_r <= STATE_RESET[7:0];
		end else begin
			fault_r <= fault_nxt;
			state_r <= state_nxt;
		end
	end

	// Power-management level and idle delays
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pm_en_r <= 1'b0;
			pm_r <= '0;
		end else begin
			pm_en_r <= pm_en_nxt;
			pm_r <= pm_nxt;
		end
	end

	// Transfer mode and host sector-time limits
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			xfer_r <= 8'h00;
			pio_t_r <= 16'h0000;
			dma_t_r <= 16'h0000;
		end else begin
			xfer_r <= xfer_nxt;
			pio_t_r <= pio_t_nxt;
			dma_t_r <= dma_t_nxt;
		end
	end

	// Cache, look-ahead, reverting, standby and serial options
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wc_r <= 1'b1;
			rla_r <= 1'b1;
			rev_r <= 1'b0;
			irq_rel_r <= 1'b0;
			puis_r <= 1'b0;
			spin_r <= 1'b0;
			ser_r <= 6'h00;
			exhaust_r <= 1'b0;
		end else begin
			wc_r <= wc_nxt;
			rla_r <= rla_nxt;
			rev_r <= rev_nxt;
			irq_rel_r <= irq_rel_nxt;
			puis_r <= puis_nxt;
			spin_r <= spin_nxt;
			ser_r <= ser_nxt;
			exhaust_r <= exhaust_nxt;
		end
	end

	assign write_cache_on = wc_r;
	assign spin_up_pulse = spin_r;
endmodule // set_features_command_decoder
`default_nettype wire

// file: sim/set_features_props.sv
// Port-level checker of the feature-setting decoder
`timescale 1ns/1ps
`default_nettype none
module set_features_props
	import setfeat_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic write_cache_on,
	input wire logic spin_up_pulse
);
	logic [7:0] feat_r, feat_nxt;
	logic dev_r, dev_nxt, ex_r, ex_nxt, wr, cmd, on_ev, off_ev, spin_ev, undef;
	assign wr = psel && penable && pwrite && pready;
	assign cmd = wr && paddr == A_COMMAND && pwdata[7:0] == OPC_SET_FEATURES && dev_r;
	assign on_ev = cmd && feat_r == FC_WC_ON;
	assign off_ev = cmd && feat_r == FC_WC_OFF || wr && paddr == A_CTRL && pwdata[0];
	assign spin_ev = cmd && feat_r == FC_SPINUP;
	assign undef = cmd && !(feat_r inside {FC_WC_ON, FC_XFER, FC_PM_ON, FC_PUIS_ON,
		FC_SPINUP, FC_SER_ON, FC_SECT_TIME, FC_EPC, FC_RLA_OFF, FC_REV_OFF, FC_WC_OFF,
		FC_PM_OFF, FC_PUIS_OFF, FC_SER_OFF, FC_RLA_ON, FC_REV_ON});
	always_comb begin
		feat_nxt = (wr && paddr == A_FEATURE) ? pwdata[7:0] : feat_r;
		dev_nxt = (wr && paddr == A_DEVICE) ? (pwdata[7:0] & DEV_REQ_MASK) == DEV_REQ_MASK
			: dev_r;
		ex_nxt = ex_r || (wr && paddr == A_CTRL && pwdata[0]);
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			feat_r <= '0;
			dev_r <= 1'b0;
			ex_r <= 1'b0;
		end else begin
			feat_r <= feat_nxt;
			dev_r <= dev_nxt;
			ex_r <= ex_nxt;
		end
	end
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	ready_after_setup_a: assert property (psel && !penable |=> pready)
		else $error("pready missing after setup");
	ready_single_a: assert property (pready |=> !pready) else $error("pready held");
	no_slverr_a: assert property (!pslverr) else $error("slave error raised");
	wc_off_cmd_a: assert property (off_ev |=> !write_cache_on)
		else $error("cache still on");
	wc_rise_cause_a: assert property ($rose(write_cache_on) |-> $past(on_ev))
		else $error("cache on without command");
	exhaust_block_a: assert property (ex_r |-> !write_cache_on)
		else $error("cache on after exhaustion");
	spin_cause_a: assert property (spin_up_pulse |-> $past(spin_ev))
		else $error("spin-up without command");
	spin_single_a: assert property (spin_up_pulse |=> !spin_up_pulse)
		else $error("spin-up pulse too long");
	undef_keep_a: assert property (undef |=> $stable(write_cache_on) && !spin_up_pulse)
		else $error("undefined code changed state");
endmodule // set_features_props
bind set_features_command_decoder set_features_props props_inst (.pclk, .presetn, .psel,
	.penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .write_cache_on,
	.spin_up_pulse);
`default_nettype wire

// file: sim/host_adapter_model.sv
// Host adapter model driving the command block over APB
`timescale 1ns/1ps
`default_nettype none
module host_adapter_model (
	input wire logic pclk,
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [11:0] paddr,
	output logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready
);
	import setfeat_pkg::*;
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = '0;
		pwdata = '0;
	end
	// Released lines show inverted values so stale data never passes
	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] q);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		q = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
		paddr <= ~a;
		pwdata <= ~d;
	endtask
	task automatic cmd(input logic [7:0] f, c, lo = 0, mid = 0, hi = 0);
		logic [31:0] q;
		xfer(1'b1, A_FEATURE, {24'h0, f}, q);
		xfer(1'b1, A_COUNT, {24'h0, c}, q);
		xfer(1'b1, A_LBA_LO, {24'h0, lo}, q);
		xfer(1'b1, A_LBA_MID, {24'h0, mid}, q);
		xfer(1'b1, A_LBA_HI, {24'h0, hi}, q);
		xfer(1'b1, A_DEVICE, 32'h0000_00A0, q);
		xfer(1'b1, A_COMMAND, {24'h0, OPC_SET_FEATURES}, q);
	endtask
endmodule // host_adapter_model
`default_nettype wire

// file: sim/set_features_command_decoder_test.sv
// Self-checking bench of the feature-setting decoder
`timescale 1ns/1ps
`default_nettype none
module set_features_command_decoder_test;
	import setfeat_pkg::*;
	logic pclk = 1'b0, presetn = 1'b0, pwrite, psel, penable, pready, pslverr, wc, spin;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, q;
	int fail_count = 0, comparisons = 0, cyc = 0, spins = 0;
	logic [7:0] modes[5] = '{8'h00, 8'h01, 8'h0C, 8'h22, 8'h46};
	logic [7:0] sels[5] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h06};
	always #20 pclk = ~pclk;
	host_adapter_model host_adapter_model_inst (.pclk, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready);
	set_features_command_decoder set_features_command_decoder_inst (.pclk, .presetn, .psel,
		.penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
		.write_cache_on(wc), .spin_up_pulse(spin));
	task automatic complete_run;
		$display("comparisons=%0d fail_count=%0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	task automatic chk(input logic [31:0] s, e);
		comparisons++;
		if (s !== e) begin
			fail_count++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	task automatic rc(input logic [11:0] a, input logic [31:0] m, e);
		host_adapter_model_inst.xfer(1'b0, a, 32'h0, q);
		chk(q & m, e);
	endtask
	// Cache level is read mid-cycle, after the edge that moves it has settled
	task automatic chk_wc(input logic e);
		@(negedge pclk);
		chk({31'h0, wc}, {31'h0, e});
	endtask
	// Hang guard well above the few hundred transfers of the run
	always @(posedge pclk) begin
		cyc++;
		if (spin === 1'b1) spins++;
		if (cyc == 8000) begin
			fail_count++;
			complete_run;
		end
	end
	initial begin
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		rc(A_FEATSTAT, 7, 3);
		rc(A_STATE, 32'hFF, 32'h40);
		chk_wc(1'b1);
		host_adapter_model_inst.cmd(8'h01, 0);
		rc(A_FAULT, 4, 4);
		rc(A_STATE, 32'hE5, 32'h41);
		host_adapter_model_inst.cmd(FC_WC_OFF, 0);
		chk_wc(1'b0);
		host_adapter_model_inst.cmd(FC_WC_ON, 0);
		chk_wc(1'b1);
		rc(A_STATE, 32'hA5, 32'h00);
		host_adapter_model_inst.cmd(FC_RLA_OFF, 0);
		rc(A_FEATSTAT, 2, 0);
		host_adapter_model_inst.cmd(FC_RLA_ON, 0);
		host_adapter_model_inst.cmd(FC_REV_ON, 0);
		rc(A_FEATSTAT, 6, 6);
		$display("test basic codes done");
		host_adapter_model_inst.cmd(FC_PM_ON, 8'h81);
		rc(A_DELAYS, 32'hFFFF, 125);
		rc(A_FEATSTAT, 32'h18, 32'h08);
		host_adapter_model_inst.cmd(FC_PM_ON, 8'h41);
		rc(A_DELAYS, '1, {16'd660, 16'd125});
		host_adapter_model_inst.cmd(FC_PM_ON, 8'hFF);
		rc(A_FAULT, 4, 4);
		host_adapter_model_inst.cmd(FC_PM_ON, 8'h00);
		rc(A_FAULT, 4, 4);
		rc(A_DELAYS, '1, {16'd660, 16'd125});
		host_adapter_model_inst.xfer(1'b1, A_CTRL, 2, q);
		rc(A_DELAYS, '1, 0);
		host_adapter_model_inst.cmd(FC_PM_ON, 8'h01);
		rc(A_DELAYS, '1, {16'd600, 16'd120});
		host_adapter_model_inst.cmd(FC_REV_OFF, 0);
		rc(A_FEATSTAT, 4, 0);
		host_adapter_model_inst.xfer(1'b1, A_CTRL, 2, q);
		rc(A_DELAYS, '1, {16'd600, 16'd120});
		host_adapter_model_inst.cmd(FC_PM_OFF, 0);
		rc(A_FEATSTAT, 32'h18, 0);
		host_adapter_model_inst.cmd(FC_PM_ON, 8'h90);
		host_adapter_model_inst.cmd(FC_PM_ON, 8'hC0);
		rc(A_FEATSTAT, 32'h38, 32'h20);
		rc(A_DELAYS, '1, 0);
		$display("test power levels done");
		foreach (sels[i]) begin
			host_adapter_model_inst.cmd(FC_SER_ON, sels[i]);
			rc(A_FEATSTAT, 32'h1 << (8 + sels[i]), 32'h1 << (8 + sels[i]));
			host_adapter_model_inst.cmd(FC_SER_OFF, sels[i]);
			rc(A_FEATSTAT, 32'h1 << (8 + sels[i]), 0);
		end
		foreach (modes[i]) begin
			host_adapter_model_inst.cmd(FC_XFER, modes[i]);
			rc(A_XFER, 32'hFF, {24'h0, modes[i]});
		end
		host_adapter_model_inst.cmd(FC_XFER, 8'h0D);
		rc(A_FAULT, 4, 4);
		rc(A_XFER, 32'hFF, 32'h46);
		host_adapter_model_inst.cmd(FC_SER_ON, 8'h05);
		rc(A_FAULT, 4, 4);
		host_adapter_model_inst.cmd(FC_SECT_TIME, 8'h34, 8'h12, 8'h78, 8'h56);
		rc(A_SECTIME, '1, 32'h5678_1234);
		host_adapter_model_inst.cmd(FC_EPC, 0);
		rc(A_STATE, 1, 0);
		host_adapter_model_inst.cmd(FC_PUIS_ON, 0);
		host_adapter_model_inst.cmd(FC_SPINUP, 0);
		host_adapter_model_inst.cmd(FC_PUIS_OFF, 0);
		host_adapter_model_inst.cmd(FC_SPINUP, 0);
		chk(spins, 1);
		host_adapter_model_inst.xfer(1'b1, A_CTRL, 1, q);
		host_adapter_model_inst.cmd(FC_WC_ON, 0);
		chk_wc(1'b0);
		rc(A_STATE, 1, 0);
		rc(12'h0FC, '1, 0);
		$display("test options done");
		complete_run;
	end
endmodule // set_features_command_decoder_test
`default_nettype wire
